// ### core/static_table_defs.svh
// Purpose: offsets, field positions and reset values of the static table
// Assumes: byte address of a register is four times its index
// Notes:   definitions only
`ifndef STATIC_TABLE_DEFS_SVH
`define STATIC_TABLE_DEFS_SVH

// ------------------------------------------------------------------
// register indices
// ------------------------------------------------------------------
`define REG_CTRL      8'h6E
`define REG_INDEX     8'h6F
`define REG_DATA_FIRST 8'h71
`define REG_DATA_LAST 8'h78
`define REG_STATUS    8'h7A

// ------------------------------------------------------------------
// control register fields
// ------------------------------------------------------------------
`define CTRL_FUNC_MSB 7
`define CTRL_FUNC_LSB 5
`define CTRL_DIR_BIT  4
`define CTRL_TSEL_MSB 3
`define CTRL_TSEL_LSB 2
`define FUNC_TABLES   3'h0
`define TSEL_STATIC   2'h0
`define CTRL_RST      8'h00
`define INDEX_RST     8'h00

// ------------------------------------------------------------------
// entry layouts
// ------------------------------------------------------------------
`define TABLE_ENTRIES 32
`define RD_FID_LSB    57
`define RD_GRP_BIT    56
`define WR_FID_LSB    56
`define WR_GRP_BIT    55
`define OVR_BIT       54
`define VALID_BIT     53
`define PORTS_LSB     48
`define BCAST_MASK    5'h1F
`define STAT_BUSY_BIT 0
`define STAT_ERR_BIT  1

`endif

// ### core/static_table_pkg.sv
// Purpose: types shared by the static address table files
// Assumes: five switch ports, seven-bit filter groups
// Notes:   field order follows the stored entry, not the bus layout
package static_table_pkg;

  typedef struct packed {
    logic [6:0]  filterGroupId;
    logic        groupMatchEnable;
    logic        override;
    logic        valid;
    logic [4:0]  ports;
    logic [47:0] mac;
  } entry_type;

  typedef enum logic {
    LK_DA = 1'b0,
    LK_SA = 1'b1
  } lookup_kind_type;

  typedef struct packed {
    lookup_kind_type kind;
    logic [47:0]     mac;
    logic [6:0]      filterGroupId;
    logic [4:0]      ingress;
  } lookup_req_type;

  typedef struct packed {
    logic       hit;
    logic       fromStatic;
    logic       override;
    logic [4:0] ports;
    logic [4:0] index;
  } lookup_rsp_type;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10
  } op_state_type;

endpackage

// ### core/static_match.sv
// Purpose: parallel compare of one look-up key against every entry
// Assumes: lowest matching index wins
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "static_table_defs.svh"
module static_match
  import static_table_pkg::*;
#(
  parameter int ENTRIES = `TABLE_ENTRIES
) (
  input  wire entry_type   tableIn [ENTRIES], // stored entries
  input  wire logic [47:0] keyMac,            // destination address
  input  wire logic [6:0]  keyGroup,          // filter group of frame
  output logic             hit,               // some entry matched
  output logic [4:0]       hitIndex,          // first matching index
  output entry_type        hitEntry           // that entry
);
  logic [ENTRIES-1:0] matchVec;

  // ------------------------------------------------------------------
  // per entry compare
  // ------------------------------------------------------------------
  for (genvar i = 0; i < ENTRIES; i++) begin : gCmp
    assign matchVec[i] = tableIn[i].valid && // R10
      tableIn[i].mac == keyMac &&
      (!tableIn[i].groupMatchEnable ||
       tableIn[i].filterGroupId == keyGroup); // R8
  end

  // ------------------------------------------------------------------
  // priority pick
  // ------------------------------------------------------------------
  always_comb begin
    hit      = 1'b0;
    hitIndex = 5'h00;
    hitEntry = '0;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (matchVec[i]) begin
        hit      = 1'b1;
        hitIndex = 5'(i);
        hitEntry = tableIn[i];
      end
    end
  end
endmodule
`default_nettype wire

// ### core/fwd_resolve.sv
// Purpose: merge static and dynamic results into one forwarding answer
// Assumes: ingress is one-hot, bit 0 is port 1
// Notes:   combinational
`timescale 1ns/1ps
`default_nettype none
`include "static_table_defs.svh"
module fwd_resolve
  import static_table_pkg::*;
(
  input  wire lookup_req_type req,      // look-up being answered
  input  wire logic      staticHit,     // static table matched
  input  wire logic [4:0] staticIndex,  // matching entry index
  input  wire entry_type staticEntry,   // matching entry
  input  wire logic      dynHit,        // dynamic table matched
  input  wire logic [4:0] dynPorts,     // dynamic port mask
  input  wire logic [4:0] txEnable,     // spanning tree transmit enables
  input  wire logic [4:0] rxEnable,     // spanning tree receive enables
  output lookup_rsp_type rsp            // merged answer
);
  logic [4:0] rawPorts;

  always_comb begin
    rsp      = '0;
    rawPorts = 5'h00;
    if (req.kind == LK_SA) begin
      rsp.hit  = dynHit; // R2
      rawPorts = dynPorts;
    end else if (staticHit) begin
      rsp.hit        = 1'b1; // R1 R3
      rsp.fromStatic = 1'b1;
      rsp.override   = staticEntry.override;
      rsp.index      = staticIndex;
      if (staticEntry.ports == `BCAST_MASK)
        rawPorts = `BCAST_MASK & ~req.ingress; // R12
      else
        rawPorts = staticEntry.ports; // R11
    end else if (dynHit) begin
      rsp.hit  = 1'b1; // R1
      rawPorts = dynPorts;
    end
    // spanning tree gating of destination look-ups unless the entry overrides it
    if (req.kind == LK_DA && !rsp.override) begin // R9
      if ((rxEnable & req.ingress) == 5'h00)
        rsp.ports = 5'h00;
      else
        rsp.ports = rawPorts & txEnable;
    end else begin
      rsp.ports = rawPorts;
    end
  end
endmodule
`default_nettype wire

// ### core/static_mac_address_table.sv
// Purpose: static forwarding-address table with indirect register access
// Assumes: classic Wishbone slave, byte address = 4 x register index
// Notes:   look-up answer one cycle after request; table never ages
//
// Operation
// [R1] destination look-up searches static and dynamic tables
// [R2] source look-up uses dynamic table only
// [R3] static hit beats dynamic hit
// [R4] entries never age or vanish by themselves
// [R5] only the manager adds, changes, deletes entries
// [R6] read layout: group 63-57, match 56, valid 53
// [R7] write layout: group 62-56, match 55
// [R8] match flag adds group compare to address
// [R9] override bypasses spanning tree port disables
// [R10] invalid entries never produce a result
// [R11] port mask bit n selects port n+1
// [R12] all-ones mask floods except ingress port
// [R13] exactly 32 entries, each indexed
// [R14] read: control, then index, then data bytes
// [R15] write: data bytes, control, then index
// [R16] index write triggers operation on that entry
// [R17] data bytes map most significant first
// [R18] function 000, table 00 selects static table
// [R19] control bit 4: one reads, zero writes
`timescale 1ns/1ps
`default_nettype none
`include "static_table_defs.svh"
module static_mac_address_table
  import static_table_pkg::*;
#(
  parameter int ENTRIES = `TABLE_ENTRIES
) (
  input  wire logic           mclk,       // 40 MHz clock
  input  wire logic           rst_n,      // async reset, active low
  input  wire logic           wbCyc,      // bus cycle
  input  wire logic           wbStb,      // bus strobe
  input  wire logic           wbWe,       // write enable
  input  wire logic [3:0]     wbSel,      // byte lanes
  input  wire logic [9:0]     wbAdr,      // byte address
  input  wire logic [31:0]    wbDatW,     // write data
  output logic [31:0]         wbDatR,     // read data
  output logic                wbAck,      // acknowledge
  input  wire logic           lkValid,    // look-up request strobe
  input  wire lookup_req_type lkReq,      // look-up key
  input  wire logic           dynHit,     // dynamic table hit
  input  wire logic [4:0]     dynPorts,   // dynamic table ports
  input  wire logic [4:0]     txEnable,   // per port transmit enable
  input  wire logic [4:0]     rxEnable,   // per port receive enable
  output logic                lkRspValid, // look-up answer strobe
  output lookup_rsp_type      lkRsp       // look-up answer
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  entry_type    tableQ [ENTRIES];
  logic [7:0]   ctrlQ;
  logic [7:0]   indexQ;
  logic [63:0]  dataQ;
  logic         ackQ;
  logic [31:0]  datRQ;
  logic         errQ;
  logic [4:0]   opIdxQ;
  op_state_type stateQ;
  op_state_type stateD;
  logic         rspValidQ;
  lookup_rsp_type rspQ;

  // ------------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------------
  logic       access;
  logic       wrLow;
  logic [7:0] regIdx;
  logic       hitData;
  logic [2:0] dataByte;
  logic [9:0] fullIdx;
  logic       selStatic;
  logic       idxOk;
  logic       trigger;
  logic       refuse;
  logic       errClear;

  assign access   = wbCyc && wbStb && !ackQ;
  assign wrLow    = access && wbWe && wbSel[0];
  assign regIdx   = wbAdr[9:2];
  assign hitData  = regIdx >= `REG_DATA_FIRST &&
                    regIdx <= `REG_DATA_LAST;
  assign dataByte = 3'(regIdx - `REG_DATA_FIRST);

  // ------------------------------------------------------------------
  // register select
  // ------------------------------------------------------------------
  logic selCtrl;
  logic selIndex;
  logic selStatus;

  assign selCtrl   = regIdx == `REG_CTRL;
  assign selIndex  = regIdx == `REG_INDEX;
  assign selStatus = regIdx == `REG_STATUS;

  // ------------------------------------------------------------------
  // indirect trigger decode
  // ------------------------------------------------------------------
  // control bits 1-0 extend the index written
  assign fullIdx  = {ctrlQ[1:0], wbDatW[7:0]};
  assign selStatic =
    ctrlQ[`CTRL_FUNC_MSB:`CTRL_FUNC_LSB] == `FUNC_TABLES &&
    ctrlQ[`CTRL_TSEL_MSB:`CTRL_TSEL_LSB] == `TSEL_STATIC; // R18
  assign idxOk    = fullIdx < 10'(ENTRIES); // R13
  assign trigger  = wrLow && selIndex &&
                    selStatic && idxOk; // R16
  assign refuse   = wrLow && selIndex &&
                    selStatic && !idxOk;
  assign errClear = wrLow && selStatus &&
                    wbDatW[`STAT_ERR_BIT];

  // ------------------------------------------------------------------
  // bus answer
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ackQ <= 1'b0;
    end else begin
      ackQ <= access;
    end
  end

  // ------------------------------------------------------------------
  // read data mux
  // ------------------------------------------------------------------
  logic [31:0] rdMux;

  always_comb begin
    rdMux = 32'h0000_0000;
    if (hitData) begin
      rdMux[7:0] = dataQ[(7 - dataByte) * 8 +: 8]; // R17
    end else begin
      case (regIdx)
        `REG_CTRL:   rdMux[7:0] = ctrlQ;
        `REG_INDEX:  rdMux[7:0] = indexQ;
        `REG_STATUS: begin
          rdMux[`STAT_BUSY_BIT] = stateQ != ST_IDLE;
          rdMux[`STAT_ERR_BIT]  = errQ;
        end
        default:     rdMux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      datRQ <= 32'h0000_0000;
    end else if (access && !wbWe) begin
      datRQ <= rdMux;
    end
  end

  // ------------------------------------------------------------------
  // bus outputs
  // ------------------------------------------------------------------
  assign wbAck  = ackQ;
  assign wbDatR = datRQ;

  // ------------------------------------------------------------------
  // control and index registers
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlQ <= `CTRL_RST;
    end else if (wrLow && selCtrl) begin
      ctrlQ <= wbDatW[7:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      indexQ <= `INDEX_RST;
    end else if (wrLow && selIndex) begin
      indexQ <= wbDatW[7:0];
    end
  end

  // ------------------------------------------------------------------
  // status register
  // ------------------------------------------------------------------
  // refused index sticks until written one; a new refusal wins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      errQ <= 1'b0;
    end else if (refuse) begin
      errQ <= 1'b1;
    end else if (errClear) begin
      errQ <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // indirect operation sequencer
  // ------------------------------------------------------------------
  always_comb begin
    stateD = ST_IDLE;
    case (stateQ)
      ST_IDLE: begin
        if (trigger) begin
          if (ctrlQ[`CTRL_DIR_BIT])
            stateD = ST_READ; // R19
          else
            stateD = ST_WRITE; // R19
        end
      end
      ST_READ:  stateD = ST_IDLE;
      ST_WRITE: stateD = ST_IDLE;
      default:  stateD = ST_IDLE;
    endcase
  end

  // ------------------------------------------------------------------
  // sequencer state register
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stateQ <= ST_IDLE;
    end else begin
      stateQ <= stateD;
    end
  end

  // ------------------------------------------------------------------
  // index capture
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      opIdxQ <= 5'h00;
    end else if (trigger) begin
      opIdxQ <= fullIdx[4:0]; // R16
    end
  end

  // ------------------------------------------------------------------
  // data byte registers
  // ------------------------------------------------------------------
  entry_type   rdEntry;
  logic [63:0] rdLayout;

  assign rdEntry = tableQ[opIdxQ];

  // read layout with bit 55 reserved as zero
  assign rdLayout = {rdEntry.filterGroupId,          // R6
                     rdEntry.groupMatchEnable,       // R6
                     1'b0,
                     rdEntry.override,
                     rdEntry.valid,
                     rdEntry.ports,
                     rdEntry.mac};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dataQ <= 64'h0000_0000_0000_0000;
    end else if (stateQ == ST_READ) begin
      dataQ <= rdLayout; // R6
    end else if (wrLow && hitData) begin
      dataQ[(7 - dataByte) * 8 +: 8] <= wbDatW[7:0]; // R17
    end
  end

  // ------------------------------------------------------------------
  // table storage: changed only by a manager write
  // ------------------------------------------------------------------
  entry_type wrEntry;

  always_comb begin
    wrEntry.filterGroupId    = dataQ[`WR_FID_LSB +: 7]; // R7
    wrEntry.groupMatchEnable = dataQ[`WR_GRP_BIT];      // R7
    wrEntry.override         = dataQ[`OVR_BIT];
    wrEntry.valid            = dataQ[`VALID_BIT];
    wrEntry.ports            = dataQ[`PORTS_LSB +: 5];
    wrEntry.mac              = dataQ[47:0];
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < ENTRIES; i++) begin
        tableQ[i] <= '0;
      end
    end else if (stateQ == ST_WRITE) begin
      tableQ[opIdxQ] <= wrEntry; // R4 R5 R15
    end
  end

  // ------------------------------------------------------------------
  // look-up path
  // ------------------------------------------------------------------
  logic           stHit;
  logic [4:0]     stIndex;
  entry_type      stEntry;
  lookup_rsp_type rspD;

  static_match #(
    .ENTRIES (ENTRIES)
  ) uMatch (
    .tableIn  (tableQ),
    .keyMac   (lkReq.mac),
    .keyGroup (lkReq.filterGroupId),
    .hit      (stHit),
    .hitIndex (stIndex),
    .hitEntry (stEntry)
  );

  fwd_resolve uResolve (
    .req         (lkReq),
    .staticHit   (stHit),
    .staticIndex (stIndex),
    .staticEntry (stEntry),
    .dynHit      (dynHit),
    .dynPorts    (dynPorts),
    .txEnable    (txEnable),
    .rxEnable    (rxEnable),
    .rsp         (rspD)
  );

  // ------------------------------------------------------------------
  // look-up answer registers
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rspValidQ <= 1'b0;
    end else begin
      rspValidQ <= lkValid;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rspQ <= '0;
    end else if (lkValid) begin
      rspQ <= rspD; // R1 R3
    end
  end

  assign lkRspValid = rspValidQ;
  assign lkRsp      = rspQ;

endmodule
`default_nettype wire

// ### tb/smat_sva.sv
// Purpose: port checks of the static address table
// Assumes: one-cycle answers on bus and look-up
// Notes:   bound into the design from tb_top
`timescale 1ns/1ps
`default_nettype none
module smat_sva
  import static_table_pkg::*;
#(
  parameter int ENTRIES = 32
) (
  input wire logic           mclk,       // clock
  input wire logic           rst_n,      // reset
  input wire logic           wbCyc,      // cycle
  input wire logic           wbStb,      // strobe
  input wire logic [31:0]    wbDatR,     // read data
  input wire logic           wbAck,      // ack
  input wire logic           lkValid,    // look-up strobe
  input wire lookup_req_type lkReq,      // look-up key
  input wire logic           dynHit,     // dynamic hit
  input wire logic [4:0]     dynPorts,   // dynamic ports
  input wire logic           lkRspValid, // answer strobe
  input wire lookup_rsp_type lkRsp       // answer
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_ack_pulse: assert property (wbAck |=> !wbAck)
    else $error("ack held too long");
  chk_ack_answer: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
    else $error("access not acked");
  chk_ack_cause: assert property (wbAck |-> $past(wbCyc && wbStb))
    else $error("ack without access");
  chk_dat_width: assert property (wbAck |-> wbDatR[31:8] == 24'h000000)
    else $error("upper read data not zero");
  chk_lk_answer: assert property (lkValid |=> lkRspValid)
    else $error("look-up not answered");
  chk_lk_cause: assert property (lkRspValid |-> $past(lkValid))
    else $error("answer without look-up");
  chk_sa_dynamic: assert property (lkValid && lkReq.kind == LK_SA |=>
    !lkRsp.fromStatic && lkRsp.hit == $past(dynHit)
    && lkRsp.ports == $past(dynPorts))
    else $error("source look-up not dynamic");
  chk_rsp_hold: assert property (!lkRspValid |-> $stable(lkRsp))
    else $error("answer changed alone");
  chk_miss_empty: assert property (lkValid && lkReq.kind == LK_DA |=>
    lkRsp.hit || lkRsp.ports == 5'h00)
    else $error("miss with ports");
  chk_static_hit: assert property (lkRsp.fromStatic |-> lkRsp.hit)
    else $error("static result without hit");
  cover property (lkRspValid && lkRsp.fromStatic);
  cover property (lkValid && lkReq.kind == LK_SA);
  cover property (wbAck && wbDatR[7:0] != 8'h00);
endmodule
`default_nettype wire

// ### tb/table_manager.sv
// Purpose: model of the table manager on the register bus
// Assumes: classic Wishbone, one access at a time
// Notes:   tasks called from tb_top
`timescale 1ns/1ps
`default_nettype none
module table_manager (
  input  wire logic        mclk,   // clock
  input  wire logic [31:0] wbDatR, // read data
  input  wire logic        wbAck,  // ack
  output logic             wbCyc,  // cycle
  output logic             wbStb,  // strobe
  output logic             wbWe,   // write
  output logic [3:0]       wbSel,  // lanes
  output logic [9:0]       wbAdr,  // address
  output logic [31:0]      wbDatW  // write data
);
  initial begin
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbSel = 4'hF;
    wbAdr = 10'h000;
    wbDatW = 32'h00000000;
  end
  // held until the ack edge, idle cycle follows
  task automatic acc(input logic w, input logic [9:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge mclk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDatW <= {24'h000000, d};
    do @(posedge mclk); while (wbAck !== 1'b1);
    q = wbDatR[7:0];
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [9:0] a, output logic [7:0] q);
    acc(1'b0, a, 8'h00, q);
  endtask
  task automatic put(input logic [4:0] i, input logic [6:0] g,
                     input logic m, o, v, input logic [4:0] p,
                     input logic [47:0] a);
    logic [63:0] w;
    w = {1'b0, g, m, o, v, p, a};
    for (int k = 0; k < 8; k++) begin
      wr(10'h1C4 + 10'(4 * k), w[63 - 8 * k -: 8]);
    end
    wr(10'h1B8, 8'h00);
    wr(10'h1BC, {3'b000, i});
  endtask
  task automatic get(input logic [4:0] i, output logic [63:0] q);
    logic [7:0] b;
    wr(10'h1B8, 8'h10);
    wr(10'h1BC, {3'b000, i});
    for (int k = 0; k < 8; k++) begin
      rd(10'h1C4 + 10'(4 * k), b);
      q[63 - 8 * k -: 8] = b;
    end
  endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Purpose: self-checking bench of the static address table
// Assumes: manager model drives the register bus
// Notes:   look-up answers checked against a queue
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import static_table_pkg::*;
;
  localparam int ENTRIES = 32;
  logic           mclk, rst_n, wbCyc, wbStb, wbWe, wbAck;
  logic           lkValid, dynHit, lkRspValid;
  logic [3:0]     wbSel;
  logic [9:0]     wbAdr;
  logic [31:0]    wbDatW, wbDatR;
  logic [4:0]     dynPorts, txEnable, rxEnable;
  logic [47:0]    macA, macB, macC;
  logic [63:0]    got;
  logic [7:0]     rb;
  lookup_req_type lkReq;
  lookup_rsp_type lkRsp;
  lookup_rsp_type expQ[$];
  int             err_total, checks, tmoCount, seed;
  logic [9:0]     adrs[5] = '{10'h1B8, 10'h1BC, 10'h1C4, 10'h1E8, 10'h3FC};
  static_mac_address_table #(.ENTRIES(ENTRIES)) i_static_mac_address_table (
    .mclk(mclk), .rst_n(rst_n), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbSel(wbSel), .wbAdr(wbAdr), .wbDatW(wbDatW), .wbDatR(wbDatR),
    .wbAck(wbAck), .lkValid(lkValid), .lkReq(lkReq), .dynHit(dynHit),
    .dynPorts(dynPorts), .txEnable(txEnable), .rxEnable(rxEnable),
    .lkRspValid(lkRspValid), .lkRsp(lkRsp));
  table_manager i_table_manager (
    .mclk(mclk), .wbDatR(wbDatR), .wbAck(wbAck), .wbCyc(wbCyc),
    .wbStb(wbStb), .wbWe(wbWe), .wbSel(wbSel), .wbAdr(wbAdr),
    .wbDatW(wbDatW));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic fail(input string m);
    err_total++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic chk_reg(input logic [63:0] g, e);
    checks++;
    if (g !== e) fail("register value");
  endtask
  task automatic chk_rsp(input lookup_rsp_type g, e);
    checks++;
    if (g.hit !== e.hit || g.fromStatic !== e.fromStatic
        || g.ports !== e.ports) fail("look-up answer");
    else if (e.fromStatic && (g.index !== e.index
        || g.override !== e.override)) fail("static entry fields");
  endtask
  task automatic look(input lookup_req_type r, input logic h,
                      input logic [4:0] p, t, x, input lookup_rsp_type e);
    lkValid <= 1'b1;
    lkReq <= r;
    dynHit <= h;
    dynPorts <= p;
    txEnable <= t;
    rxEnable <= x;
    expQ.push_back(e);
    @(posedge mclk);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(negedge mclk) begin
    if (lkRspValid === 1'b1) begin
      if (expQ.size() == 0) fail("unexpected answer");
      else chk_rsp(lkRsp, expQ.pop_front());
    end
  end
  always @(posedge mclk) begin
    tmoCount++;
    if (tmoCount == 20000) begin
      fail("timeout");
      end_of_test();
    end
  end
  initial begin
    {rst_n, lkValid, dynHit, err_total, checks, tmoCount} = '0;
    {lkReq, dynPorts, txEnable, rxEnable} = '0;
    seed = 66;
    macA = {16'($random(seed)), 32'($random(seed))};
    macB = {16'($random(seed)), 32'($random(seed))};
    macC = {16'($random(seed)), 32'($random(seed))};
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (adrs[i]) begin
      i_table_manager.rd(adrs[i], rb);
      chk_reg(64'(rb), 64'h0);
    end
    $display("test reset values done");
    i_table_manager.put(5'h03, 7'h00, 1'b0, 1'b0, 1'b1, 5'h06, macA);
    i_table_manager.put(5'h1F, 7'h05, 1'b1, 1'b1, 1'b1, 5'h1F, macB);
    i_table_manager.put(5'h00, 7'h00, 1'b0, 1'b0, 1'b0, 5'h01, macC);
    i_table_manager.get(5'h03, got);
    chk_reg(got, {7'h00, 4'h1, 5'h06, macA});
    i_table_manager.get(5'h1F, got);
    chk_reg(got, {7'h05, 4'hB, 5'h1F, macB});
    i_table_manager.get(5'h00, got);
    chk_reg(got, {7'h00, 4'h0, 5'h01, macC});
    i_table_manager.wr(10'h1B8, 8'h11);
    i_table_manager.wr(10'h1BC, 8'h00);
    i_table_manager.rd(10'h1E8, rb);
    chk_reg(64'(rb[1]), 64'h1);
    i_table_manager.wr(10'h1E8, 8'h02);
    i_table_manager.wr(10'h1B8, 8'h04);
    i_table_manager.wr(10'h1BC, 8'h03);
    i_table_manager.rd(10'h1E8, rb);
    chk_reg(64'(rb[1]), 64'h0);
    $display("test table access done");
    look('{LK_DA, macA, 7'h2A, 5'h01}, 1, 5'h10, 5'h1F, 5'h1F,
         '{1, 1, 0, 5'h06, 5'h03});
    look('{LK_SA, macA, 7'h00, 5'h01}, 1, 5'h10, 5'h1F, 5'h1F,
         '{1, 0, 0, 5'h10, 5'h00});
    look('{LK_DA, macB, 7'h05, 5'h01}, 0, 5'h00, 5'h1F, 5'h1F,
         '{1, 1, 1, 5'h1E, 5'h1F});
    look('{LK_DA, macB, 7'h06, 5'h01}, 0, 5'h00, 5'h1F, 5'h1F,
         '{0, 0, 0, 5'h00, 5'h00});
    look('{LK_DA, macC, 7'h00, 5'h01}, 0, 5'h00, 5'h1F, 5'h1F,
         '{0, 0, 0, 5'h00, 5'h00});
    look('{LK_DA, macC, 7'h00, 5'h01}, 1, 5'h04, 5'h1F, 5'h1F,
         '{1, 0, 0, 5'h04, 5'h00});
    look('{LK_DA, macA, 7'h00, 5'h01}, 0, 5'h00, 5'h1F, 5'h1E,
         '{1, 1, 0, 5'h00, 5'h03});
    look('{LK_DA, macA, 7'h00, 5'h01}, 0, 5'h00, 5'h1B, 5'h1F,
         '{1, 1, 0, 5'h02, 5'h03});
    look('{LK_DA, macB, 7'h05, 5'h02}, 0, 5'h00, 5'h00, 5'h1D,
         '{1, 1, 1, 5'h1D, 5'h1F});
    lkValid <= 1'b0;
    repeat (3) @(posedge mclk);
    if (expQ.size() != 0) fail("answers missing");
    $display("test look-ups done");
    i_table_manager.get(5'h03, got);
    chk_reg(got, {7'h00, 4'h1, 5'h06, macA});
    $display("test entry kept done");
    end_of_test();
  end
endmodule
bind static_mac_address_table smat_sva #(.ENTRIES(ENTRIES)) i_smat_sva (
  .mclk(mclk), .rst_n(rst_n), .wbCyc(wbCyc), .wbStb(wbStb),
  .wbDatR(wbDatR), .wbAck(wbAck), .lkValid(lkValid), .lkReq(lkReq),
  .dynHit(dynHit), .dynPorts(dynPorts), .lkRspValid(lkRspValid),
  .lkRsp(lkRsp));
`default_nettype wire
